/* core/prox_regs_pkg.sv */
package prox_regs_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h0d;
  localparam logic [7:0] ADDR_PULSE = 8'h0e;
  localparam logic [7:0] ADDR_CONTROL = 8'h0f;
  localparam logic [7:0] ADDR_ID = 8'h12;
  localparam logic [7:0] ADDR_STATUS = 8'h13;
  localparam logic [7:0] ADDR_RES_LO = 8'h18;
  localparam logic [7:0] ADDR_RES_HI = 8'h19;
  localparam logic [7:0] ADDR_OFFSET = 8'h1e;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_DRIVE_LSB = 6;
  localparam int CTRL_DIODE_LSB = 4;
  localparam int CTRL_GAIN_LSB = 2;
  localparam int EN_IRQ_BIT = 5;
  localparam int CFG_REDUCE_BIT = 0;
  localparam int OFF_SIGN_BIT = 7;
  localparam int STAT_SAT_BIT = 6;
  localparam int STAT_IRQ_BIT = 5;
  localparam int STAT_VALID_BIT = 1;

  // ----------------------------------------
  // Values after reset, and the infrared diode code
  // ----------------------------------------
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_PULSE = 8'h08;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [1:0] DIODE_INFRARED = 2'h2;

  // ----------------------------------------
  // Emitter current, tenths of a milliamp, and the reduced-drive offset divisor
  // ----------------------------------------
  localparam logic [9:0] CUR_NORMAL_0 = 10'h3e8;
  localparam logic [9:0] CUR_NORMAL_1 = 10'h1f4;
  localparam logic [9:0] CUR_NORMAL_2 = 10'h0fa;
  localparam logic [9:0] CUR_NORMAL_3 = 10'h07d;
  localparam logic [9:0] CUR_REDUCED_0 = 10'h06f;
  localparam logic [9:0] CUR_REDUCED_1 = 10'h038;
  localparam logic [9:0] CUR_REDUCED_2 = 10'h01c;
  localparam logic [9:0] CUR_REDUCED_3 = 10'h00e;
  localparam logic [17:0] REDUCE_DIVISOR = 18'h00009;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic saturated;
    logic [15:0] raw;
  } sample_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] cfg;
    logic [7:0] pulse;
    logic [7:0] control;
    logic [7:0] offset;
    logic [15:0] result;
    logic [7:0] shadow_hi;
    logic sat;
    logic valid;
    logic irq;
    logic [7:0] rdata;
    logic rvalid;
    logic [9:0] current;
  } bank_state_t;

endpackage

/* core/proximity_sensor_register_bank.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Control bits 7:6 pick normal emitter current.
// RQ2: Reduced drive maps codes to lower currents.
// RQ3: Host sets photodiode select to infrared code.
// RQ4: Control bits 3:2 set gain 1x to 8x.
// RQ5: Low two control bits reserved, ignored.
// RQ6: Identification register fixed, read only.
// RQ7: Status register read only, reserved bits zero.
// RQ8: Status bit 6 flags saturated result.
// RQ9: Status bit 5 mirrors interrupt output.
// RQ10: Status bit 1 set after completed integration.
// RQ11: Sixteen bit result, low and high bytes.
// RQ12: Low byte read captures high byte shadow.
// RQ13: High byte stays coherent across new results.
// RQ14: Host reads low byte first, two bytes.
// RQ15: Offset bit 7 sign, one shifts positive.
// RQ16: Offset shift scales with gain, drive, pulses.
// RQ17: Offset magnitude lives in bits 6:0.
// RQ18: Configuration bit 0 reduces emitter drive.
// RQ19: Interrupt only while interrupt enable set.
module proximity_sensor_register_bank #(
  parameter logic [7:0] ID_VALUE = 8'ha5 // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic rst,
  input wire prox_regs_pkg::reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire prox_regs_pkg::sample_t sample,
  input wire logic irq_request,
  output logic proximity_irq,
  output logic [1:0] emitter_current_code,
  output logic emitter_current_reduce,
  output logic [9:0] emitter_current_tenth_ma,
  output logic [1:0] photodiode_select,
  output logic [1:0] measurement_gain,
  output logic [7:0] emitter_pulse_count
);

  prox_regs_pkg::bank_state_t st_r;
  prox_regs_pkg::bank_state_t st_nxt;
  logic [16:0] comp_sum;
  logic [15:0] comp_shift;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Emitter current for a drive code and drive level
  function automatic logic [9:0] drive_current(input logic [1:0] code, input logic reduce);
    logic [9:0] cur;
    cur = prox_regs_pkg::CUR_NORMAL_0;
    if (reduce) begin
      case (code)
        2'h0: cur = prox_regs_pkg::CUR_REDUCED_0;
        2'h1: cur = prox_regs_pkg::CUR_REDUCED_1;
        2'h2: cur = prox_regs_pkg::CUR_REDUCED_2;
        default: cur = prox_regs_pkg::CUR_REDUCED_3;
      endcase
    end else begin
      case (code)
        2'h0: cur = prox_regs_pkg::CUR_NORMAL_0;
        2'h1: cur = prox_regs_pkg::CUR_NORMAL_1;
        2'h2: cur = prox_regs_pkg::CUR_NORMAL_2;
        default: cur = prox_regs_pkg::CUR_NORMAL_3;
      endcase
    end
    return cur;
  endfunction

  // Offset shift scaled by gain, pulse count and drive strength
  function automatic logic [15:0] offset_shift(input logic [6:0] mag, input logic [1:0] gain,
                                               input logic [1:0] code, input logic reduce,
                                               input logic [7:0] pulses);
    logic [17:0] s;
    s = 18'({8'h00, mag} << gain) * {10'h000, pulses};
    s = s >> code;
    if (reduce) begin
      s = s / prox_regs_pkg::REDUCE_DIVISOR;
    end
    return (s[17:16] != 2'h0) ? 16'hffff : s[15:0];
  endfunction

  // ----------------------------------------
  // Offset compensation of each sample
  // ----------------------------------------

  // Sign-magnitude shift, clamped to the result range
  always_comb begin
    comp_shift = offset_shift(st_r.offset[6:0], // RQ17
                              st_r.control[3:2], st_r.control[7:6],
                              st_r.cfg[prox_regs_pkg::CFG_REDUCE_BIT], st_r.pulse); // RQ16
    if (st_r.offset[prox_regs_pkg::OFF_SIGN_BIT]) begin // RQ15
      comp_sum = {1'b0, sample.raw} + {1'b0, comp_shift};
    end else begin
      comp_sum = {1'b0, sample.raw} - {1'b0, comp_shift};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Register writes, sample capture, read answers
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (req.wr) begin
      case (req.addr)
        prox_regs_pkg::ADDR_ENABLE: st_nxt.enable = req.wdata;
        prox_regs_pkg::ADDR_CONFIG: st_nxt.cfg = req.wdata;
        prox_regs_pkg::ADDR_PULSE: st_nxt.pulse = req.wdata;
        prox_regs_pkg::ADDR_CONTROL: st_nxt.control = {req.wdata[7:2], 2'h0}; // RQ5
        prox_regs_pkg::ADDR_OFFSET: st_nxt.offset = req.wdata;
        default: ; // ID, status and result ignore writes
      endcase
    end
    if (sample.valid) begin
      // Clamp at both ends, saturation reported
      if (comp_sum[16]) begin
        st_nxt.result = st_r.offset[prox_regs_pkg::OFF_SIGN_BIT] ? 16'hffff : 16'h0000; // RQ11
      end else begin
        st_nxt.result = comp_sum[15:0];
      end
      st_nxt.sat = sample.saturated | comp_sum[16]; // RQ8
      st_nxt.valid = 1'b1; // RQ10
    end
    st_nxt.irq = irq_request & st_r.enable[prox_regs_pkg::EN_IRQ_BIT]; // RQ19
    st_nxt.current = drive_current(st_r.control[7:6], st_r.cfg[prox_regs_pkg::CFG_REDUCE_BIT]); // RQ1 RQ2 RQ18
    if (req.rd) begin
      st_nxt.rvalid = 1'b1;
      case (req.addr)
        prox_regs_pkg::ADDR_ENABLE: st_nxt.rdata = st_r.enable;
        prox_regs_pkg::ADDR_CONFIG: st_nxt.rdata = st_r.cfg;
        prox_regs_pkg::ADDR_PULSE: st_nxt.rdata = st_r.pulse;
        prox_regs_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control;
        prox_regs_pkg::ADDR_ID: st_nxt.rdata = ID_VALUE; // RQ6
        prox_regs_pkg::ADDR_STATUS: st_nxt.rdata = {1'b0, st_r.sat, st_r.irq, 3'h0, st_r.valid, 1'b0}; // RQ7 RQ9
        prox_regs_pkg::ADDR_RES_LO: begin
          st_nxt.rdata = st_r.result[7:0];
          st_nxt.shadow_hi = st_r.result[15:8]; // RQ12
        end
        prox_regs_pkg::ADDR_RES_HI: st_nxt.rdata = st_r.shadow_hi; // RQ13
        prox_regs_pkg::ADDR_OFFSET: st_nxt.rdata = st_r.offset;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.enable <= prox_regs_pkg::RST_ENABLE;
      st_r.cfg <= prox_regs_pkg::RST_CONFIG;
      st_r.pulse <= prox_regs_pkg::RST_PULSE;
      st_r.control <= prox_regs_pkg::RST_CONTROL;
      st_r.offset <= prox_regs_pkg::RST_OFFSET;
      st_r.current <= prox_regs_pkg::CUR_NORMAL_0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // All straight from the state register
  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;
  assign proximity_irq = st_r.irq; // RQ9
  assign emitter_current_code = st_r.control[7:6]; // RQ1
  assign emitter_current_reduce = st_r.cfg[prox_regs_pkg::CFG_REDUCE_BIT]; // RQ18
  assign emitter_current_tenth_ma = st_r.current;
  assign photodiode_select = st_r.control[5:4];
  assign measurement_gain = st_r.control[3:2]; // RQ4
  assign emitter_pulse_count = st_r.pulse;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_drive_normal;
    (!st_r.cfg[0] && st_r.control[7:6] == 2'h0) |=> (emitter_current_tenth_ma == 10'h3e8);
  endproperty
  a_drive_normal: assert property (p_drive_normal) else $error("normal drive current wrong"); // RQ1

  property p_drive_reduced;
    (st_r.cfg[0] && st_r.control[7:6] == 2'h3) |=> (emitter_current_tenth_ma == 10'h00e);
  endproperty
  a_drive_reduced: assert property (p_drive_reduced) else $error("reduced drive current wrong"); // RQ2

  property p_gain_write;
    (req.wr && req.addr == 8'h0f) |=> (measurement_gain == $past(req.wdata[3:2]));
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain not taken from write"); // RQ4

  property p_reserved_ctrl;
    (req.rd && req.addr == 8'h0f) |=> (rvalid && rdata[1:0] == 2'h0);
  endproperty
  a_reserved_ctrl: assert property (p_reserved_ctrl) else $error("reserved control bits not zero"); // RQ5

  property p_id_read;
    (req.rd && req.addr == 8'h12) |=> (rvalid && rdata == ID_VALUE);
  endproperty
  a_id_read: assert property (p_id_read) else $error("identification read wrong"); // RQ6

  property p_status_reserved;
    (req.rd && req.addr == 8'h13) |=> (rdata[7] == 1'b0 && rdata[4:2] == 3'h0 && rdata[0] == 1'b0);
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("status reserved bits set"); // RQ7

  property p_sat_flag;
    (sample.valid && sample.saturated) |=> st_r.sat;
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("saturation flag missing"); // RQ8

  property p_irq_gate;
    !st_r.enable[5] |=> !proximity_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled"); // RQ19

  property p_irq_status;
    (req.rd && req.addr == 8'h13) |=> (rdata[5] == $past(proximity_irq));
  endproperty
  a_irq_status: assert property (p_irq_status) else $error("status interrupt bit wrong"); // RQ9

  property p_valid_set;
    sample.valid |=> (st_r.valid ##1 st_r.valid);
  endproperty
  a_valid_set: assert property (p_valid_set) else $error("valid flag not held"); // RQ10

  property p_shadow_pair;
    (req.rd && req.addr == 8'h18) ##1 (req.rd && req.addr == 8'h19) |=> (rdata == $past(st_r.result[15:8], 2));
  endproperty
  a_shadow_pair: assert property (p_shadow_pair) else $error("high byte not coherent"); // RQ13

  property p_shadow_capture;
    (req.rd && req.addr == 8'h18) |=> (st_r.shadow_hi == $past(st_r.result[15:8]));
  endproperty
  a_shadow_capture: assert property (p_shadow_capture) else $error("shadow not captured"); // RQ12

  property p_offset_none;
    (sample.valid && !sample.saturated && st_r.offset[6:0] == 7'h00) |=> (st_r.result == $past(sample.raw));
  endproperty
  a_offset_none: assert property (p_offset_none) else $error("zero offset altered result"); // RQ17

  property p_offset_sign;
    (sample.valid && st_r.offset[7]) |=> (st_r.result >= $past(sample.raw));
  endproperty
  a_offset_sign: assert property (p_offset_sign) else $error("positive offset lowered result"); // RQ15

  property p_offset_pulses;
    (sample.valid && st_r.pulse == 8'h00) |=> (st_r.result == $past(sample.raw));
  endproperty
  a_offset_pulses: assert property (p_offset_pulses) else $error("offset applied with no pulses"); // RQ16

  property p_drive_half;
    (!st_r.cfg[0] && st_r.control[7:6] == 2'h1) |=> (emitter_current_tenth_ma == 10'h1f4);
  endproperty
  a_drive_half: assert property (p_drive_half) else $error("half drive current wrong"); // RQ1

  property p_drive_quarter;
    (!st_r.cfg[0] && st_r.control[7:6] == 2'h2) |=> (emitter_current_tenth_ma == 10'h0fa);
  endproperty
  a_drive_quarter: assert property (p_drive_quarter) else $error("quarter drive current wrong"); // RQ1

  property p_drive_code;
    (req.wr && req.addr == 8'h0f) |=> (emitter_current_code == $past(req.wdata[7:6]));
  endproperty
  a_drive_code: assert property (p_drive_code) else $error("drive code not taken from write"); // RQ1

  property p_reduced_low;
    (st_r.cfg[0] && st_r.control[7:6] == 2'h0) |=> (emitter_current_tenth_ma == 10'h06f);
  endproperty
  a_reduced_low: assert property (p_reduced_low) else $error("reduced drive code zero wrong"); // RQ2

  property p_reduced_mid;
    (st_r.cfg[0] && st_r.control[7:6] == 2'h1) |=> (emitter_current_tenth_ma == 10'h038);
  endproperty
  a_reduced_mid: assert property (p_reduced_mid) else $error("reduced drive code one wrong"); // RQ2

  property p_reduce_write;
    (req.wr && req.addr == 8'h0d) |=> (emitter_current_reduce == $past(req.wdata[0]));
  endproperty
  a_reduce_write: assert property (p_reduce_write) else $error("drive level not taken from write"); // RQ18

  property p_diode_write;
    (req.wr && req.addr == 8'h0f) |=> (photodiode_select == $past(req.wdata[5:4]));
  endproperty
  a_diode_write: assert property (p_diode_write) else $error("diode select not taken from write"); // RQ3

  property p_status_sat_bit;
    (req.rd && req.addr == 8'h13) |=> (rdata[6] == $past(st_r.sat));
  endproperty
  a_status_sat_bit: assert property (p_status_sat_bit) else $error("status saturation bit wrong"); // RQ8

  property p_sat_clear;
    (sample.valid && !sample.saturated && st_r.offset[6:0] == 7'h00) |=> !st_r.sat;
  endproperty
  a_sat_clear: assert property (p_sat_clear) else $error("saturation flag stuck"); // RQ8

  property p_irq_follow;
    (irq_request && st_r.enable[5]) |=> proximity_irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("enabled interrupt not raised"); // RQ19

  property p_status_valid_bit;
    (req.rd && req.addr == 8'h13) |=> (rdata[1] == $past(st_r.valid));
  endproperty
  a_status_valid_bit: assert property (p_status_valid_bit) else $error("status valid bit wrong"); // RQ10

  property p_valid_sticky;
    st_r.valid |=> st_r.valid;
  endproperty
  a_valid_sticky: assert property (p_valid_sticky) else $error("valid flag dropped"); // RQ10

  property p_low_byte;
    (req.rd && req.addr == 8'h18) |=> (rvalid && rdata == $past(st_r.result[7:0]));
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low result byte wrong"); // RQ11

  property p_result_ro;
    (req.wr && req.addr == 8'h18 && !sample.valid) |=> (st_r.result == $past(st_r.result));
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by write"); // RQ11

  property p_offset_neg;
    (sample.valid && !st_r.offset[7]) |=> (st_r.result <= $past(sample.raw));
  endproperty
  a_offset_neg: assert property (p_offset_neg) else $error("negative offset raised result"); // RQ15

  c_pair_read: cover property ((req.rd && req.addr == 8'h18) ##1 (req.rd && req.addr == 8'h19));
  c_sample_between: cover property ((req.rd && req.addr == 8'h18) ##1 sample.valid ##1 (req.rd && req.addr == 8'h19));
  c_saturated: cover property (sample.valid && sample.saturated);
  c_irq: cover property (!proximity_irq ##1 proximity_irq);
  c_reduced: cover property (emitter_current_reduce && emitter_current_code == 2'h3);

endmodule

/* sim/host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Host controller model
// ----------------------------------------
module host_model (
  input wire logic clk,
  output prox_regs_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;

  // One write strobe, launched and released on falling edges
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge clk);
    req <= '0;
  endtask

  // Single read, answer awaited under a bound
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        data = rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask

  // Two-byte fetch, low byte first, back to back
  task automatic rd_pair(output logic [15:0] data, output logic ok);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: prox_regs_pkg::ADDR_RES_LO, wdata: 8'h00};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: prox_regs_pkg::ADDR_RES_HI, wdata: 8'h00};
    ok = rvalid === 1'b1;
    data[7:0] = rdata;
    @(negedge clk);
    req <= '0;
    ok = ok && rvalid === 1'b1;
    data[15:8] = rdata;
  endtask

  // Control setup with infrared diode and zero low bits
  task automatic setup(input logic [1:0] drive, input logic [1:0] gain);
    wr(prox_regs_pkg::ADDR_CONTROL, {drive, 2'h2, gain, 2'h0});
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  typedef struct {logic [7:0] off; logic [1:0] gain; logic red; logic [15:0] raw; logic [15:0] res;} off_t;
  localparam logic [7:0] ID_TEST = 8'h5c; // Arbitrary identification value
  logic clk = 1'b0;
  logic rst = 1'b1;
  prox_regs_pkg::reg_req_t req;
  prox_regs_pkg::sample_t sample = '0;
  logic irq_request = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic proximity_irq;
  logic [1:0] cur_code;
  logic cur_reduce;
  logic [9:0] cur_tenth;
  logic [1:0] diode_sel;
  logic [1:0] gain;
  logic [7:0] pulses;
  int errors = 0;
  int n_tests = 0;
  logic [7:0] got;
  logic ok;
  logic [15:0] pair;
  row_t rows [8] = '{'{8'h0f, 8'hab, 8'ha8}, '{8'h12, 8'h00, ID_TEST}, '{8'h13, 8'hff, 8'h00},
    '{8'h18, 8'h55, 8'h00}, '{8'h19, 8'haa, 8'h00}, '{8'h1e, 8'h85, 8'h85}, '{8'h0e, 8'h10, 8'h10},
    '{8'h2a, 8'h77, 8'h00}};
  off_t offs [6] = '{'{8'h81, 2'h0, 1'b0, 16'h0100, 16'h0108}, '{8'h01, 2'h0, 1'b0, 16'h0100, 16'h00f8},
    '{8'h81, 2'h1, 1'b0, 16'h0100, 16'h0110}, '{8'h89, 2'h0, 1'b1, 16'h0100, 16'h0108},
    '{8'h01, 2'h0, 1'b0, 16'h0004, 16'h0000}, '{8'h81, 2'h0, 1'b0, 16'hfffc, 16'hffff}};
  logic [9:0] cur_exp [8] = '{10'h3e8, 10'h1f4, 10'h0fa, 10'h07d, 10'h06f, 10'h038, 10'h01c, 10'h00e};

  // Clock at 125 MHz
  always #4 clk = ~clk;

  proximity_sensor_register_bank #(.ID_VALUE(ID_TEST)) i_proximity_sensor_register_bank (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .sample(sample),
    .irq_request(irq_request), .proximity_irq(proximity_irq), .emitter_current_code(cur_code),
    .emitter_current_reduce(cur_reduce), .emitter_current_tenth_ma(cur_tenth),
    .photodiode_select(diode_sel), .measurement_gain(gain), .emitter_pulse_count(pulses));
  host_model i_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
    n_tests++;
    if (got_v !== exp_v) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp_v);
    i_host_model.rd(addr, got, ok);
    check({15'h0, ok}, 16'h0001);
    check({8'h0, got}, {8'h0, exp_v});
  endtask

  task automatic push(input logic [15:0] raw, input logic sat);
    @(negedge clk);
    sample <= '{valid: 1'b1, saturated: sat, raw: raw};
    @(negedge clk);
    sample <= '0;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    // Register table through the host
    foreach (rows[i]) begin
      i_host_model.wr(rows[i].addr, rows[i].wdata);
      read_chk(rows[i].addr, rows[i].exp);
    end
    check({8'h0, pulses}, 16'h0010);
    // Every drive code at both levels, gain alongside
    for (int k = 0; k < 8; k++) begin
      i_host_model.wr(8'h0d, {7'h0, k[2]});
      i_host_model.setup(k[1:0], k[1:0]);
      @(negedge clk);
      check({6'h0, cur_tenth}, {6'h0, cur_exp[k]});
      check({11'h0, cur_reduce, gain, cur_code}, {11'h0, k[2], k[1:0], k[1:0]});
      check({14'h0, diode_sel}, 16'h0002);
    end
    // Coherent pair with a new result landing mid-read
    i_host_model.wr(8'h1e, 8'h00);
    i_host_model.wr(8'h0e, 8'h08);
    i_host_model.wr(8'h0d, 8'h00);
    i_host_model.setup(2'h0, 2'h0);
    push(16'h1234, 1'b0);
    fork
      i_host_model.rd_pair(pair, ok);
      push(16'habcd, 1'b0);
    join
    check(pair, 16'h1234);
    check({15'h0, ok}, 16'h0001);
    i_host_model.rd_pair(pair, ok);
    check(pair, 16'habcd);
    check({15'h0, ok}, 16'h0001);
    read_chk(8'h13, 8'h02);
    push(16'h0010, 1'b1);
    read_chk(8'h13, 8'h42);
    // Offset sign, magnitude and scaling
    foreach (offs[i]) begin
      i_host_model.wr(8'h0d, {7'h0, offs[i].red});
      i_host_model.setup(2'h0, offs[i].gain);
      i_host_model.wr(8'h1e, offs[i].off);
      push(offs[i].raw, 1'b0);
      i_host_model.rd_pair(pair, ok);
      check(pair, offs[i].res);
    end
    // No pulses, no shift despite a set offset
    i_host_model.wr(8'h0e, 8'h00);
    push(16'h0100, 1'b1);
    i_host_model.rd_pair(pair, ok);
    check(pair, 16'h0100);
    read_chk(8'h13, 8'h42);
    // Interrupt gated by its enable
    irq_request = 1'b1;
    repeat (3) @(negedge clk);
    check({15'h0, proximity_irq}, 16'h0000);
    read_chk(8'h13, 8'h42);
    i_host_model.wr(8'h00, 8'h20);
    @(negedge clk);
    check({15'h0, proximity_irq}, 16'h0001);
    read_chk(8'h13, 8'h62);
    irq_request = 1'b0;
    @(negedge clk);
    check({15'h0, proximity_irq}, 16'h0000);
    // Reset in mid-run
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({6'h0, cur_tenth}, 16'h03e8);
    check({8'h0, pulses}, 16'h0008);
    read_chk(8'h13, 8'h00);
    read_chk(8'h0f, 8'h00);
    read_chk(8'h00, 8'h00);
    end_of_test();
  end
endmodule
